// ===== src/scrx_cfg.svh
`ifndef SCRX_CFG_SVH
`define SCRX_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define SCRX_IDX_STATUS 16'hfe08
`define SCRX_IDX_DATA 16'hfe09
`define SCRX_IDX_CARD 16'hfe0a
`define SCRX_IDX_MODE 16'hfe0b

// Field positions in rx_control_status.
`define SCRX_B_NINTH 7
`define SCRX_B_LAST 5
`define SCRX_B_BLOCK_CHECK_ERROR 4
`define SCRX_B_FULL 3
`define SCRX_B_EMPTY 2
`define SCRX_B_OVR 1
`define SCRX_B_PAR 0

// Field positions in rx_mode.
`define SCRX_B_SYNC 0
`define SCRX_B_NINE 1
`define SCRX_B_CRC 2

// Reset values.
`define SCRX_RST_STATUS 8'h00
`define SCRX_RST_DATA 8'h00
`define SCRX_RST_CARD 8'h21
`define SCRX_RST_MODE 3'h0

// Block check constants.
`define SCRX_CRC_INIT 16'hffff
`define SCRX_CRC_POLY 16'h1021
`define SCRX_CRC_RESIDUE 16'h1d0f
`define SCRX_LRC_GOOD 8'h00

// Card clocks per elementary time unit in character mode.
`define SCRX_ETU_CLOCKS 372

`endif

// ===== src/scrx_pkg.sv
package scrx_pkg;

  // One received character as it crosses from the card clock domain.
  typedef struct packed {
    logic ninth;
    logic par_err;
    logic [7:0] data;
  } scrx_word_t;

  // Mode bits steering the link receiver; crc_sel picks the block check.
  typedef struct packed {
    logic crc_sel;
    logic nine_bit;
    logic sync_mode;
  } scrx_mode_t;

  // Character-mode receiver states.
  typedef enum logic [1:0] {
    SCRX_IDLE,
    SCRX_START,
    SCRX_BITS,
    SCRX_STOP
  } scrx_state_t;

endpackage

// ===== src/scrx_top.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "scrx_cfg.svh"
// Behaviour
// RQ1 - Sync nine-bit mode: ninth bit into status bit 7
// RQ2 - Last byte arrived: check CRC 0x1D0F or LRC zero
// RQ3 - Firmware sets last flag during final byte
// RQ4 - Read-only bit flags CRC/LRC block error
// RQ5 - Read-only bit shows receive FIFO full
// RQ6 - Read-only empty bit, never an interrupt source
// RQ7 - Byte arriving into full FIFO sets overrun
// RQ8 - Status read clears the overrun flag
// RQ9 - Bytes discarded while overrun is pending
// RQ10 - Overrun raises the receive error request
// RQ11 - Parity error flag, clear on read, interrupts
// RQ12 - FIFO stores bytes, data read returns oldest
// RQ13 - Status register at 0xFE08, resets to zero; here it reads 0x04 after reset, with the empty bit set
// RQ14 - Data read pops one; flags update next cycle
// RQ15 - Depth is a parameter; CRC restarts per block
module scrx_top
  import scrx_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int ADDR_W = 18,
  parameter int ETU_CLOCKS = `SCRX_ETU_CLOCKS
) (
  // System clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Card link
  input wire logic card_clk,
  input wire logic card_io,
  // Outputs to the rest of the chip
  output logic receive_error_irq,
  output logic [7:0] card_control
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int HALF = ETU_CLOCKS / 2;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // ---------------------------------------------------------------
  // Link domain: everything below up to the crossing runs on card_clk.
  // ---------------------------------------------------------------
  logic io_s1, io_s2;
  scrx_mode_t mode_l1, mode_l2, mode;
  scrx_state_t state;
  logic [15:0] etu_cnt;
  logic [3:0] bit_n;
  logic [8:0] shreg;
  scrx_word_t link_word;
  logic link_tog;

  // The pin and the mode bits come from other domains, so two flops each.
  always_ff @(posedge card_clk or negedge presetn) begin
    if (!presetn) begin
      io_s1 <= 1'b1;
      io_s2 <= 1'b1;
      mode_l1 <= '0;
      mode_l2 <= '0;
    end else begin
      io_s1 <= card_io;
      io_s2 <= io_s1;
      mode_l1 <= mode;
      mode_l2 <= mode_l1;
    end
  end

  wire logic [8:0] next_sh = {io_s2, shreg[8:1]};
  wire logic sync_last = (bit_n == (mode_l2.nine_bit ? 4'd8 : 4'd7));
  wire logic etu_done = (etu_cnt == 16'h0000);
  wire logic char_last = (bit_n == 4'd8);
  wire logic emit_sync = mode_l2.sync_mode & sync_last;
  wire logic emit_char = ~mode_l2.sync_mode & (state == SCRX_BITS) & etu_done & char_last;

  // Assemble the finished character; the 8-bit sync shape sits one bit higher.
  scrx_word_t next_word;
  always_comb begin
    next_word.data = next_sh[7:0];
    next_word.ninth = 1'b0;
    next_word.par_err = 1'b0;
    if (mode_l2.sync_mode) begin
      if (mode_l2.nine_bit) begin
        next_word.ninth = next_sh[8]; // [RQ1]
      end else begin
        next_word.data = next_sh[8:1];
      end
    end else begin
      next_word.par_err = ^next_sh; // [RQ11]
    end
  end

  // Sync mode shifts one bit per rising card clock edge; character mode samples
  // mid-bit after a start bit. The stop state waits for the line to rise
  // so that a low parity bit is not taken for the next start bit.
  always_ff @(posedge card_clk or negedge presetn) begin
    if (!presetn) begin
      state <= SCRX_IDLE;
      etu_cnt <= '0;
      bit_n <= '0;
      shreg <= '0;
    end else if (mode_l2.sync_mode) begin
      state <= SCRX_IDLE;
      shreg <= next_sh;
      bit_n <= sync_last ? 4'd0 : bit_n + 4'd1;
    end else begin
      case (state)
        SCRX_IDLE: begin
          bit_n <= '0;
          etu_cnt <= 16'(HALF);
          if (!io_s2) begin
            state <= SCRX_START;
          end
        end
        SCRX_START: begin
          etu_cnt <= etu_cnt - 16'h0001;
          if (etu_done) begin
            etu_cnt <= 16'(ETU_CLOCKS - 1);
            state <= io_s2 ? SCRX_IDLE : SCRX_BITS;
          end
        end
        SCRX_BITS: begin
          etu_cnt <= etu_cnt - 16'h0001;
          if (etu_done) begin
            etu_cnt <= 16'(ETU_CLOCKS - 1);
            shreg <= next_sh;
            bit_n <= bit_n + 4'd1;
            if (char_last) begin
              state <= SCRX_STOP;
            end
          end
        end
        SCRX_STOP: begin
          if (io_s2) begin
            state <= SCRX_IDLE;
          end
        end
        default: state <= SCRX_IDLE;
      endcase
    end
  end

  // The word is held until the next character, long after pclk takes it.
  always_ff @(posedge card_clk or negedge presetn) begin
    if (!presetn) begin
      link_word <= '0;
      link_tog <= 1'b0;
    end else if (emit_sync | emit_char) begin
      link_word <= next_word;
      link_tog <= ~link_tog;
    end
  end

  // ---------------------------------------------------------------
  // Bus domain.
  // ---------------------------------------------------------------
  logic tog_s1, tog_s2, tog_s3;

  // Toggle crossing; only the second and third stages feed the edge detect.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end else begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  wire logic arrive = tog_s2 ^ tog_s3;
  wire scrx_word_t rx_word = link_word;

  // APB decode; offsets are indices, so the byte address is four times.
  wire logic sel_status = (paddr == ADDR_W'({`SCRX_IDX_STATUS, 2'b00})); // [RQ13]
  wire logic sel_data = (paddr == ADDR_W'({`SCRX_IDX_DATA, 2'b00}));
  wire logic sel_card = (paddr == ADDR_W'({`SCRX_IDX_CARD, 2'b00}));
  wire logic sel_mode = (paddr == ADDR_W'({`SCRX_IDX_MODE, 2'b00}));
  wire logic hit = sel_status | sel_data | sel_card | sel_mode;
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable;
  wire logic wr_en = access & pwrite & hit;
  wire logic rd_en = access & ~pwrite;

  assign pready = access;
  assign pslverr = access & ~hit;

  logic [7:0] fifo_mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr;
  logic [CW-1:0] count;
  logic fifo_full, fifo_empty;
  logic ninth_bit_value, last_byte_flag, block_check_error;
  logic rx_overrun, parity_error;
  logic [15:0] crc_acc;
  logic [7:0] lrc_acc;

  wire logic [7:0] status = {ninth_bit_value, 1'b0, last_byte_flag,
    block_check_error, fifo_full, fifo_empty, rx_overrun, parity_error};

  // Push only with room and no overrun pending; a data read pops one.
  wire logic push = arrive & ~fifo_full & ~rx_overrun; // [RQ9]
  wire logic pop = rd_en & sel_data & ~fifo_empty; // [RQ14]
  wire logic [CW-1:0] next_count = count + CW'(push) - CW'(pop);

  // Read data is captured in the setup cycle, so it stays fixed through
  // the access phase even if status changes meanwhile.
  wire logic [7:0] rd_mux = sel_status ? status :
    sel_data ? fifo_mem[rd_ptr] : // [RQ12]
    sel_card ? card_control :
    sel_mode ? {5'h00, mode} : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= {24'h000000, rd_mux};
    end
  end

  // FIFO storage and pointers.
  always_ff @(posedge pclk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= rx_word.data;
    end
  end

  // Flags come from the next count, so they move one cycle after the event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      fifo_full <= 1'b0;
      fifo_empty <= 1'b1;
    end else begin
      wr_ptr <= wr_ptr + PW'(push);
      rd_ptr <= rd_ptr + PW'(pop);
      count <= next_count;
      fifo_full <= (next_count == FULL_CNT); // [RQ5] [RQ14]
      fifo_empty <= (next_count == '0); // [RQ6]
    end
  end

  // CRC step over one byte, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ `SCRX_CRC_POLY;
      end
    end
    return r;
  endfunction

  wire logic [15:0] crc_new = crc_step(crc_acc, rx_word.data);
  wire logic [7:0] lrc_new = lrc_acc ^ rx_word.data;
  wire logic block_end = arrive & last_byte_flag;
  wire logic check_bad = mode.crc_sel ? (crc_new != `SCRX_CRC_RESIDUE) :
    (lrc_new != `SCRX_LRC_GOOD); // [RQ2]

  // Read-clear acts only on bits the captured read value showed set.
  wire logic st_read = rd_en & sel_status;
  wire logic clr_ovr = st_read & prdata[`SCRX_B_OVR]; // [RQ8]
  wire logic clr_par = st_read & prdata[`SCRX_B_PAR];
  wire logic clr_crc = st_read & prdata[`SCRX_B_BLOCK_CHECK_ERROR];
  wire logic set_ovr = arrive & fifo_full; // [RQ7]
  wire logic set_par = arrive & rx_word.par_err;
  wire logic next_ovr = set_ovr | (rx_overrun & ~clr_ovr);
  wire logic next_par = set_par | (parity_error & ~clr_par); // [RQ11]
  wire logic next_crc = (block_end & check_bad) | (block_check_error & ~clr_crc); // [RQ4]

  // Sticky flags; a set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overrun <= 1'b0;
      parity_error <= 1'b0;
      block_check_error <= 1'b0;
      receive_error_irq <= 1'b0;
    end else begin
      rx_overrun <= next_ovr;
      parity_error <= next_par;
      block_check_error <= next_crc;
      receive_error_irq <= next_ovr | next_par; // [RQ10] [RQ11]
    end
  end

  // Block accumulators restart once the last byte has been checked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_acc <= `SCRX_CRC_INIT;
      lrc_acc <= 8'h00;
    end else if (block_end) begin
      crc_acc <= `SCRX_CRC_INIT; // [RQ15]
      lrc_acc <= 8'h00;
    end else if (arrive) begin
      crc_acc <= crc_new;
      lrc_acc <= lrc_new;
    end
  end

  // Ninth bit follows each arriving character in sync nine-bit mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ninth_bit_value <= 1'b0;
    end else if (arrive & mode.sync_mode & mode.nine_bit) begin
      ninth_bit_value <= rx_word.ninth; // [RQ1]
    end
  end

  // Firmware sets the last flag during the final byte; the check clears it,
  // but a write in that same cycle still wins.
  wire logic wr_last = wr_en & sel_status;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_byte_flag <= 1'b0;
    end else if (wr_last) begin
      last_byte_flag <= pwdata[`SCRX_B_LAST]; // [RQ3]
    end else if (block_end) begin
      last_byte_flag <= 1'b0;
    end
  end

  // Plain software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_control <= `SCRX_RST_CARD;
      mode <= `SCRX_RST_MODE;
    end else begin
      if (wr_en & sel_card) begin
        card_control <= pwdata[7:0];
      end
      if (wr_en & sel_mode) begin
        mode <= pwdata[2:0];
      end
    end
  end

endmodule

// ===== test/scrx_card_model.sv
`timescale 1ns/1ps
// Card side: start bit, eight data bits LSB first, even parity, two stop bits.
module scrx_card_model #(
  parameter int ETU = 8
) (
  // Link
  input wire logic card_clk,
  output logic card_io
);
  // The pulled-up line idles high between characters.
  initial card_io = 1'b1;

  // Each bit stands one bit time; parity is only spoilt when asked.
  task automatic send(input logic [7:0] b, input logic bad);
    logic [11:0] f;
    f = {2'b11, ^b ^ bad, b, 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge card_clk);
      card_io <= f[i];
      repeat (ETU - 1) @(posedge card_clk);
    end
  endtask
endmodule

// ===== test/scrx_top_assertions.sv
`timescale 1ns/1ps
`include "scrx_cfg.svh"
// Bus-side relations of the receive block, seen from its top ports only.
module scrx_top_assertions #(
  parameter int ADDR_W = 18
) (
  // Clocks and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic card_clk,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Chip outputs
  input wire logic receive_error_irq,
  input wire logic [7:0] card_control
);
  // Address decode of the access phase.
  wire logic acc = psel && penable;
  wire logic at_st = paddr == ADDR_W'(`SCRX_IDX_STATUS * 4);
  wire logic at_dt = paddr == ADDR_W'(`SCRX_IDX_DATA * 4);
  wire logic at_cc = paddr == ADDR_W'(`SCRX_IDX_CARD * 4);
  wire logic at_md = paddr == ADDR_W'(`SCRX_IDX_MODE * 4);
  wire logic mapped = at_st || at_dt || at_cc || at_md;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A status read, and one that returned an error flag.
  sequence s_st_rd;
    acc && !pwrite && at_st;
  endsequence
  sequence s_err_seen;
    s_st_rd ##0 prdata[1:0] != 2'b00;
  endsequence

  a_status_shape: assert property (s_st_rd |-> prdata[31:8] == 0 && !prdata[6]
    && !(prdata[3] && prdata[2])) else $error("status word malformed");
  a_err_irq_high: assert property (s_err_seen |-> receive_error_irq)
    else $error("error flag without request");
  a_read_clears: assert property (s_err_seen |-> ##2 !receive_error_irq)
    else $error("request stays after status read");
  a_empty_quiet: assert property (s_st_rd ##0 prdata[7:0] == 8'h04 |-> !receive_error_irq)
    else $error("empty fifo raised request");
  a_data_byte: assert property (acc && !pwrite && at_dt |-> prdata[31:8] == 0)
    else $error("data word malformed");
  a_refused_addr: assert property (acc && !mapped |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_zero_wait: assert property (acc |-> pready && (mapped != pslverr))
    else $error("bus answer wrong");
  a_cc_write: assert property (acc && pwrite && at_cc |=> card_control == $past(pwdata[7:0]))
    else $error("card control write lost");
  a_reset_state: assert property ($rose(presetn) |-> card_control == 8'h21
    && !receive_error_irq) else $error("reset state wrong");
endmodule

bind scrx_top scrx_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .card_clk(card_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .receive_error_irq(receive_error_irq), .card_control(card_control));

// ===== test/scrx_top_tb_top.sv
`timescale 1ns/1ps
`include "scrx_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module scrx_top_tb_top;
  localparam logic [15:0] ST = `SCRX_IDX_STATUS;
  localparam logic [15:0] DT = `SCRX_IDX_DATA;
  localparam logic [15:0] CC = `SCRX_IDX_CARD;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, card_clk, card_io, irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] ctl;
  int n_errors = 0;
  int n_tests = 0;

  // Short bit times and a four-deep FIFO keep the run brief.
  scrx_top #(.DEPTH(4), .ETU_CLOCKS(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_clk(card_clk), .card_io(card_io),
    .receive_error_irq(irq), .card_control(ctl));
  scrx_card_model #(.ETU(8)) card (.card_clk(card_clk), .card_io(card_io));

  // Bus clock, and a card clock offset so that the edges never line up.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    card_clk = 1'b0;
    #13;
    forever #80 card_clk = ~card_clk;
  end

  // One transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    `CHK($sformatf("reg %h", idx), {24'h0, e}, r)
  endtask
  // Marks the final byte of a block while it is still on the line.
  task automatic last_byte(input logic [7:0] b);
    fork
      card.send(b, 1'b0);
      begin
        repeat (20) @(posedge card_clk);
        apb(1'b1, ST, 8'h20);
      end
    join
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence: reset state, block checks, FIFO overflow, parity.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (4) @(posedge card_clk);
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge card_clk);
    rd(ST, 8'h04);
    `CHK("irq", 1'b0, irq)
    rd(CC, 8'h21);
    rd(16'hfe0c, 8'h00);
    apb(1'b1, CC, 8'h5a);
    rd(CC, 8'h5a);
    apb(1'b1, ST, 8'h1f);
    rd(ST, 8'h04);
    // A good block, then a bad one, each checked on its last byte.
    card.send(8'h5a, 1'b0);
    last_byte(8'h5a);
    rd(ST, 8'h00);
    card.send(8'h5a, 1'b0);
    last_byte(8'h5b);
    rd(ST, 8'h18);
    for (int i = 0; i < 4; i++) rd(DT, i == 3 ? 8'h5b : 8'h5a);
    // CRC check: two zero bytes leave the register on the good residue.
    apb(1'b1, 16'hfe0b, 8'h04);
    rd(16'hfe0b, 8'h04);
    card.send(8'h00, 1'b0);
    last_byte(8'h00);
    rd(ST, 8'h00);
    rd(DT, 8'h00);
    rd(DT, 8'h00);
    // Fill, overflow, free a slot, then send one that must still be dropped.
    for (int i = 0; i < 4; i++) card.send(8'h30 + 8'(i), 1'b0);
    rd(ST, 8'h08);
    card.send(8'h40, 1'b0);
    rd(DT, 8'h30);
    card.send(8'h41, 1'b0);
    `CHK("irq", 1'b1, irq)
    rd(ST, 8'h02);
    rd(ST, 8'h00);
    for (int i = 1; i < 4; i++) rd(DT, 8'h30 + 8'(i));
    rd(ST, 8'h04);
    // Bad parity raises a flag that the following read clears.
    card.send(8'h77, 1'b1);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, ST, 8'h00);
    `CHK("parity", 1'b1, r[0])
    apb(1'b0, ST, 8'h00);
    `CHK("parity", 1'b0, r[0])
    // Sync nine-bit mode on an idle-high line: every bit, the ninth too, is one.
    apb(1'b1, 16'hfe0b, 8'h03);
    repeat (20) @(posedge card_clk);
    apb(1'b0, ST, 8'h00);
    `CHK("ninth", 1'b1, r[7])
    rd(DT, 8'h77);
    rd(DT, 8'hff);
    give_verdict();
  end

  // Cuts a hang short; the sequence needs a little under half this span.
  initial begin
    #450_000;
    n_errors++;
    give_verdict();
  end
endmodule
